/* File: core/wsm_top.sv */
// Watchdog status monitor: I/O decode, timebase, status and outputs
`timescale 1ns/1ps
module wsm_top #(
  parameter int RST_HOLD_CYC = wsm_pkg::RST_HOLD_CYC,
  parameter int FAN_WIN_CYC  = wsm_pkg::FAN_WIN_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [9:0]  io_addr,
  input  wire logic        aen,
  input  wire logic        ior_n,
  input  wire logic        iow_n,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  input  wire logic [9:0]  base_sel,
  input  wire logic [3:0]  irq_sel,
  output logic      [15:0] irq_out,
  output logic      [15:0] irq_oe,
  input  wire logic        color_clk,
  input  wire logic        fan_tach,
  input  wire logic        isolated_input_zero,
  input  wire logic        isolated_input_one,
  input  wire logic        overvolt_in,
  input  wire logic        undervolt_in,
  input  wire logic        temp_hot_in,
  input  wire logic [7:0]  temp_adc,
  output logic             wd_reset,
  output logic             wd_reset_n,
  output logic             buzzer
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  localparam int SW = 50;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_p1_q;
  logic [SW-1:0] pin_p2_q;

  assign pin_raw = {io_addr, aen, ior_n, iow_n, data_in, base_sel,
                    irq_sel, color_clk, fan_tach, isolated_input_zero,
                    isolated_input_one, overvolt_in, undervolt_in,
                    temp_hot_in, temp_adc};

  // Only the second stage is read anywhere
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_p1_q <= '0;
      pin_p2_q <= {10'h000, 3'b111, {(SW-13){1'b0}}};
    end else if (ce) begin
      pin_p1_q <= pin_raw;
      pin_p2_q <= pin_p1_q;
    end
  end

  logic [9:0] s_addr;
  logic       s_aen;
  logic       s_ior_n;
  logic       s_iow_n;
  logic [7:0] s_data;
  logic [9:0] s_base;
  logic [3:0] s_irq_sel;
  logic       s_color;
  logic       s_tach;
  logic       s_iso0;
  logic       s_iso1;
  logic       s_over;
  logic       s_under;
  logic       s_hot;
  logic [7:0] s_adc;

  assign {s_addr, s_aen, s_ior_n, s_iow_n, s_data, s_base, s_irq_sel,
          s_color, s_tach, s_iso0, s_iso1, s_over, s_under, s_hot,
          s_adc} = pin_p2_q;

  // ---------------------------------------------------------------
  // Address decode and strobes
  // ---------------------------------------------------------------
  logic       iow_prev_q;
  logic       color_prev_q;
  logic       tach_prev_q;
  logic       in_window;
  logic [9:0] offset;
  logic       wr_stb;
  logic       rd_act;

  function automatic logic hit(input logic [9:0] ofs,
                               input logic [9:0] want);
    hit = (ofs == want);
  endfunction

  // Base may sit anywhere in the 10-bit space; offsets wrap
  assign offset    = 10'(s_addr - s_base);
  assign in_window = !s_aen && (offset <= wsm_pkg::OFS_STATUS);
  // Write taken on the trailing edge when data are settled
  assign wr_stb    = in_window && s_iow_n && !iow_prev_q;
  assign rd_act    = in_window && !s_ior_n;

  // ---------------------------------------------------------------
  // Counter programming
  // ---------------------------------------------------------------
  logic [2:0] mode_q [0:2];
  logic [2:0] msb_next_q;
  logic [7:0] lsb_q [0:2];
  logic       armed0_q;
  logic       armed1_q;
  logic       ctl_wr;
  logic [1:0] ctl_sel;
  logic       ld0;
  logic       ld1;
  logic [15:0] ld_val0;
  logic [15:0] ld_val1;

  assign ctl_wr  = wr_stb && hit(offset, wsm_pkg::OFS_CTRL);
  assign ctl_sel = s_data[wsm_pkg::CTL_SEL_HI:wsm_pkg::CTL_SEL_LO];
  // Counts load as low byte then high byte
  assign ld0 = wr_stb && hit(offset, wsm_pkg::OFS_CNT0) && msb_next_q[0];
  assign ld1 = wr_stb && hit(offset, wsm_pkg::OFS_CNT1) && msb_next_q[1];
  assign ld_val0 = {s_data, lsb_q[0]};
  assign ld_val1 = {s_data, lsb_q[1]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        mode_q[i] <= wsm_pkg::MODE_0;
        lsb_q[i]  <= 8'h00;
      end
      msb_next_q <= 3'b000;
    end else if (ce && wr_stb) begin
      if (ctl_wr && ctl_sel != 2'b11) begin
        mode_q[ctl_sel] <=
          s_data[wsm_pkg::CTL_MODE_HI:wsm_pkg::CTL_MODE_LO];
        msb_next_q[ctl_sel] <= 1'b0;
      end
      for (int i = 0; i < 3; i++) begin
        if (offset == 10'(i)) begin
          if (!msb_next_q[i])
            lsb_q[i] <= s_data;
          msb_next_q[i] <= !msb_next_q[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Timebase: color clock over sixteen feeds the cascade
  // ---------------------------------------------------------------
  logic [3:0]  div_q;
  logic        tick;
  logic [15:0] cnt0;
  logic [15:0] cnt1;
  logic        tc0;
  logic        tc1;
  logic        armed;
  logic        timeout;

  assign tick  = s_color && !color_prev_q && (div_q == 4'hF);
  assign armed = armed0_q && armed1_q && !wd_reset;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= 4'h0;
    end else if (ce && s_color && !color_prev_q) begin
      div_q <= 4'(div_q + 4'h1);
    end
  end

  wsm_counter u_cnt0 (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .load     (ld0),
    .load_val (ld_val0),
    .dec      (tick && armed),
    .count_q  (cnt0),
    .tc_q     (tc0)
  );

  // Second counter steps on the first one's terminal count
  wsm_counter u_cnt1 (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .load     (ld1),
    .load_val (ld_val1),
    .dec      (tc0 && armed),
    .count_q  (cnt1),
    .tc_q     (tc1)
  );

  // Software chooses the span by its loads; reloading is the refresh
  assign timeout = tc1 && armed;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed0_q <= 1'b0;
      armed1_q <= 1'b0;
    end else if (ce) begin
      armed0_q <= !timeout && (armed0_q || ld0);
      armed1_q <= !timeout && (armed1_q || ld1);
    end
  end

  // ---------------------------------------------------------------
  // Reset output hold
  // ---------------------------------------------------------------
  logic [31:0] hold_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_q     <= 32'h0000_0000;
      wd_reset   <= 1'b0;
      wd_reset_n <= 1'b1;
    end else if (ce) begin
      if (timeout)
        hold_q <= 32'(RST_HOLD_CYC - 1);
      else if (hold_q != 32'h0000_0000)
        hold_q <= 32'(hold_q - 32'h1);
      wd_reset   <= timeout || (hold_q != 32'h0000_0000);
      wd_reset_n <= !(timeout || (hold_q != 32'h0000_0000));
    end
  end

  // ---------------------------------------------------------------
  // Monitors: reminder, fan, change of state
  // ---------------------------------------------------------------
  logic        remind_q;
  logic        fan_ok_q;
  logic [31:0] fan_cnt_q;
  logic [4:0]  lvl_q;
  logic        remind_rise;
  logic        fan_fail;
  logic        iso_change;
  logic        volt_rise;
  logic        hot_rise;
  logic        tach_edge;

  // Last first-counter period before timeout
  assign remind_rise = armed && (cnt1 == 16'h0001) && !remind_q;
  assign tach_edge   = s_tach && !tach_prev_q;
  // No tach pulse within one minimum-rate period means too slow
  assign fan_fail    = fan_ok_q && !tach_edge &&
                       (fan_cnt_q == 32'(FAN_WIN_CYC - 1));
  assign iso_change  = ({s_iso0, s_iso1} != lvl_q[4:3]);
  assign volt_rise   = (s_over && !lvl_q[2]) || (s_under && !lvl_q[1]);
  assign hot_rise    = s_hot && !lvl_q[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Edge detectors start at their pins' idle levels; pin_p1_q resets iow_n low, so iow_n shows one false edge after reset
      remind_q     <= 1'b0;
      fan_ok_q     <= 1'b1;
      fan_cnt_q    <= 32'h0000_0000;
      lvl_q        <= 5'h00;
      iow_prev_q   <= 1'b1;
      color_prev_q <= 1'b0;
      tach_prev_q  <= 1'b0;
    end else if (ce) begin
      remind_q     <= armed && (cnt1 == 16'h0001);
      lvl_q        <= {s_iso0, s_iso1, s_over, s_under, s_hot};
      iow_prev_q   <= s_iow_n;
      color_prev_q <= s_color;
      tach_prev_q  <= s_tach;
      if (tach_edge) begin
        fan_cnt_q <= 32'h0000_0000;
        fan_ok_q  <= 1'b1;
      end else if (fan_cnt_q != 32'(FAN_WIN_CYC - 1)) begin
        fan_cnt_q <= 32'(fan_cnt_q + 32'h1);
      end else begin
        fan_ok_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt pulse and line routing
  // ---------------------------------------------------------------
  logic [7:0] irq_cnt_q;
  logic       irq_evt;
  logic       irq_act;

  // Only the lines the card can reach are ever driven
  function automatic logic irq_line_ok(input logic [3:0] n);
    case (n)
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
      4'hA, 4'hB, 4'hC, 4'hE, 4'hF: irq_line_ok = 1'b1;
      default:                      irq_line_ok = 1'b0;
    endcase
  endfunction

  assign irq_evt = remind_rise || fan_fail || iso_change ||
                   volt_rise || hot_rise;
  assign irq_act = (irq_cnt_q != 8'h00);

  // Short pulse, then released so the line can be shared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_cnt_q <= 8'h00;
      irq_out   <= 16'h0000;
      irq_oe    <= 16'h0000;
    end else if (ce) begin
      if (irq_evt)
        irq_cnt_q <= 8'(wsm_pkg::IRQ_PULSE_CYC);
      else if (irq_act)
        irq_cnt_q <= 8'(irq_cnt_q - 8'h01);
      for (int i = 0; i < 16; i++) begin
        irq_out[i] <= irq_act && (s_irq_sel == 4'(i)) && irq_line_ok(s_irq_sel);
        irq_oe[i]  <= irq_act && (s_irq_sel == 4'(i)) && irq_line_ok(s_irq_sel);
      end
    end
  end

  // ---------------------------------------------------------------
  // Status byte and read path
  // ---------------------------------------------------------------
  logic [7:0] status;
  logic [7:0] rd_mux;

  assign status[wsm_pkg::ST_REMIND] = !remind_q;
  assign status[wsm_pkg::ST_TEMPOK] = !s_hot;
  assign status[wsm_pkg::ST_ISO1]   = s_iso1;
  assign status[wsm_pkg::ST_ISO0]   = s_iso0;
  assign status[wsm_pkg::ST_FANOK]  = !fan_ok_q;
  assign status[wsm_pkg::ST_OVER]   = !s_over;
  assign status[wsm_pkg::ST_UNDER]  = !s_under;
  assign status[wsm_pkg::ST_IRQ]    = !irq_act;

  // Reads are side-effect free: nothing below feeds back
  assign rd_mux =
    hit(offset, wsm_pkg::OFS_STATUS) ? status :
    hit(offset, wsm_pkg::OFS_ISO)    ? {6'h00, s_iso1, s_iso0} :
    hit(offset, wsm_pkg::OFS_TEMP)   ? s_adc :
    hit(offset, wsm_pkg::OFS_CNT0)   ? cnt0[7:0] :
    hit(offset, wsm_pkg::OFS_CNT1)   ? cnt1[7:0] :
    8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else if (ce) begin
      data_out <= rd_mux;
      data_oe  <= rd_act;
    end
  end

  // ---------------------------------------------------------------
  // Buzzer
  // ---------------------------------------------------------------
  logic buz_on_q;

  // Only the on and off writes move the latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buz_on_q <= 1'b0;
      buzzer   <= 1'b0;
    end else if (ce) begin
      if (wr_stb && hit(offset, wsm_pkg::OFS_BUZ_ON))
        buz_on_q <= 1'b1;
      else if (wr_stb && hit(offset, wsm_pkg::OFS_BUZOFF))
        buz_on_q <= 1'b0;
      // Mode 0 on the third counter defeats it entirely
      buzzer <= buz_on_q && (mode_q[2] == wsm_pkg::MODE_1);
    end
  end
endmodule

/* File: core/wsm_pkg.sv */
// Shared constants for the watchdog status monitor
// Operation
// - Over- and undervoltage bits, with interrupt
// - Temperature comparator readable, interrupts when hot
// - Eight-bit converted temperature readable
// - Isolated input levels reported; changes interrupt
// - Slow fan tachometer raises interrupt
// - Mode 1: write +4 on, +5 off
// - Mode 0 keeps buzzer silent
// - Two complementary reset outputs
// - Bit 0 low while refresh reminder
// - Bit 1 high while temperature good
// - Bits 2,3 follow isolated inputs 1,0
// - Bit 4 fan good, active low
// - Bits 5,6 low on over/undervoltage
// - Bit 7 low while interrupt raised
// - Reset held at least 16 ms
// - Counter clock is color clock over 16
// - Read at +4 returns isolated inputs
// - Base address anywhere in 10-bit space
// - Interrupt routed to one selectable line
// - First counter output clocks second counter
// - Timeout when both counters reach zero
// - Interrupt one first-counter period before timeout
package wsm_pkg;
  // -------------------------------------------------------------
  // Register offsets from the selected base
  // -------------------------------------------------------------
  localparam logic [9:0] OFS_CNT0   = 10'h000;
  localparam logic [9:0] OFS_CNT1   = 10'h001;
  localparam logic [9:0] OFS_CNT2   = 10'h002;
  localparam logic [9:0] OFS_CTRL   = 10'h003;
  localparam logic [9:0] OFS_BUZ_ON = 10'h004;
  localparam logic [9:0] OFS_BUZOFF = 10'h005;
  localparam logic [9:0] OFS_ISO    = 10'h004;
  localparam logic [9:0] OFS_TEMP   = 10'h005;
  localparam logic [9:0] OFS_STATUS = 10'h006;
  // -------------------------------------------------------------
  // Control word fields and counter modes
  // -------------------------------------------------------------
  localparam int CTL_SEL_HI  = 7;
  localparam int CTL_SEL_LO  = 6;
  localparam int CTL_MODE_HI = 3;
  localparam int CTL_MODE_LO = 1;
  localparam logic [2:0] MODE_0 = 3'h0;
  localparam logic [2:0] MODE_1 = 3'h1;
  // -------------------------------------------------------------
  // Status bit positions
  // -------------------------------------------------------------
  localparam int ST_REMIND = 0;
  localparam int ST_TEMPOK = 1;
  localparam int ST_ISO1   = 2;
  localparam int ST_ISO0   = 3;
  localparam int ST_FANOK  = 4;
  localparam int ST_OVER   = 5;
  localparam int ST_UNDER  = 6;
  localparam int ST_IRQ    = 7;
  // -------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int COLOR_DIV     = 16;
  localparam int RST_HOLD_MS   = 16;
  localparam int RST_HOLD_CYC  = RST_HOLD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FAN_MIN_PPS   = 50;
  localparam int FAN_WIN_CYC   = 1000000000 / FAN_MIN_PPS / CLK_PERIOD_NS;
  localparam int IRQ_PULSE_NS  = 1000;
  localparam int IRQ_PULSE_CYC = IRQ_PULSE_NS / CLK_PERIOD_NS;
  localparam logic [15:0] CNT_RESET = 16'h0000;
endpackage

/* File: core/wsm_counter.sv */
// Sixteen-bit reloading down counter for the watchdog timebase
`timescale 1ns/1ps
module wsm_counter (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic        dec,
  output logic      [15:0] count_q,
  output logic             tc_q
);
  logic [15:0] reload_q;
  logic        at_one;
  logic [15:0] next_cnt;

  // A loaded zero divides by 65536, the longest span software can pick
  assign at_one   = (count_q == 16'h0001);
  assign next_cnt = at_one ? reload_q : 16'(count_q - 16'h0001);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reload_q <= wsm_pkg::CNT_RESET;
      count_q  <= wsm_pkg::CNT_RESET;
      tc_q     <= 1'b0;
    end else if (ce) begin
      tc_q <= 1'b0;
      if (load) begin
        reload_q <= load_val;
        count_q  <= load_val;
      end else if (dec) begin
        count_q <= next_cnt;
        tc_q    <= at_one;
      end
    end
  end
endmodule

/* File: verif/wsm_top_properties.sv */
// Concurrent checks on the watchdog status monitor ports
`timescale 1ns/1ps
module wsm_top_checker #(
  parameter int RST_HOLD_CYC = 50
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        aen,
  input wire logic        ior_n,
  input wire logic        iow_n,
  input wire logic        data_oe,
  input wire logic [15:0] irq_out,
  input wire logic [15:0] irq_oe,
  input wire logic        wd_reset,
  input wire logic        wd_reset_n,
  input wire logic        buzzer
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // -------------------------------------------------------------
  // Helper counters
  // -------------------------------------------------------------
  int unsigned hold_cnt_q;
  logic [3:0]  since_wr_q;
  // Saturates so a long quiet spell never wraps back into the window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_cnt_q <= 0;
      since_wr_q <= 4'hF;
    end else begin
      hold_cnt_q <= wd_reset ? hold_cnt_q + 1 : 0;
      since_wr_q <= !iow_n ? 4'h0 : (since_wr_q == 4'hF ? 4'hF : since_wr_q + 4'h1);
    end
  end
  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  a_reset_pair_opposed: assert property (wd_reset_n != wd_reset)
    else $error("reset outputs not complementary");
  a_reset_hold_long: assert property ($fell(wd_reset) |-> hold_cnt_q >= RST_HOLD_CYC)
    else $error("reset released too early");
  a_irq_legal_lines: assert property ((irq_oe & 16'h2303) == 16'h0000)
    else $error("interrupt driven on unavailable line");
  a_irq_single_line: assert property ($onehot0(irq_oe))
    else $error("interrupt driven on several lines");
  a_irq_out_enabled: assert property ((irq_out & ~irq_oe) == 16'h0000)
    else $error("interrupt level without drive enable");
  a_dma_no_drive: assert property (aen [*4] |-> !data_oe)
    else $error("data bus driven during dma cycle");
  a_read_released: assert property (ior_n [*4] |-> !data_oe)
    else $error("data bus still driven after read");
  a_buzzer_on_write: assert property ($rose(buzzer) |-> since_wr_q <= 4'hA)
    else $error("buzzer sounded without a write");
  a_buzzer_off_write: assert property ($fell(buzzer) |-> since_wr_q <= 4'hA)
    else $error("buzzer silenced without a write");
endmodule

/* File: verif/wsm_host_model.sv */
// Host processor model running I/O bus cycles against the card
`timescale 1ns/1ps
module wsm_host_model (
  input  wire logic       clk,
  output logic      [9:0] io_addr,
  output logic            aen,
  output logic            ior_n,
  output logic            iow_n,
  output logic      [7:0] data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  initial begin
    io_addr = 10'h000;
    aen = 1'b0;
    ior_n = 1'b1;
    iow_n = 1'b1;
    data_in = 8'h00;
  end
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Address and data held six cycles past the strobe, data then driven inverted
  task automatic wr(input logic [9:0] addr, input logic [7:0] d, input logic dma);
    io_addr = addr;
    data_in = d;
    aen = dma;
    iow_n = 1'b0;
    edges(4);
    iow_n = 1'b1;
    edges(6);
    aen = 1'b0;
    data_in = ~d;
  endtask
  task automatic rd(input logic [9:0] addr, output logic [7:0] d);
    int n;
    io_addr = addr;
    ior_n = 1'b0;
    n = 0;
    while (data_oe !== 1'b1 && n < 8) begin
      edges(1);
      n++;
    end
    d = (data_oe === 1'b1) ? data_out : 8'hXX;
    ior_n = 1'b1;
    edges(4);
  endtask
  // Low byte then high byte; the high byte arms the count
  task automatic load(input logic [9:0] addr, input logic [15:0] val);
    wr(addr, val[7:0], 1'b0);
    wr(addr, val[15:8], 1'b0);
  endtask
endmodule

/* File: verif/wsm_top_tb.sv */
// Self-checking testbench for the watchdog status monitor
`timescale 1ns/1ps
module wsm_top_tb;
  localparam logic [9:0] BASE = 10'h3F8;
  localparam logic [15:0] IRQ_LINES = 16'hDCFC;
  logic        clk, rst, color_clk, fan_tach, fan_run, iso0, iso1, over, under, hot, ce;
  logic [3:0]  irq_sel;
  logic [7:0]  temp_adc, data_in, data_out, d;
  logic [9:0]  io_addr, base_sel;
  logic        aen, ior_n, iow_n, data_oe, wd_reset, wd_reset_n, buzzer;
  logic [15:0] irq_out, irq_oe;
  int          errors, tests_run;
  wsm_top #(.RST_HOLD_CYC(50), .FAN_WIN_CYC(200)) u_wsm_top (
    .clk(clk), .rst(rst), .ce(ce), .io_addr(io_addr), .aen(aen), .ior_n(ior_n),
    .iow_n(iow_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .base_sel(base_sel), .irq_sel(irq_sel), .irq_out(irq_out), .irq_oe(irq_oe),
    .color_clk(color_clk), .fan_tach(fan_tach), .isolated_input_zero(iso0),
    .isolated_input_one(iso1), .overvolt_in(over), .undervolt_in(under),
    .temp_hot_in(hot), .temp_adc(temp_adc), .wd_reset(wd_reset),
    .wd_reset_n(wd_reset_n), .buzzer(buzzer));
  wsm_host_model u_host (
    .clk(clk), .io_addr(io_addr), .aen(aen), .ior_n(ior_n), .iow_n(iow_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    color_clk = 1'b0;
    #3.3;
    forever #34.92 color_clk = ~color_clk;
  end
  initial begin
    fan_tach = 1'b0;
    forever begin
      u_host.edges(10);
      fan_tach = fan_run ? ~fan_tach : 1'b0;
    end
  end
  // -------------------------------------------------------------
  // Compare and report
  // -------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic results;
    $display("errors %0d, checks %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Fan assumed good and watchdog idle
  function automatic logic [7:0] status_want(input logic irq_on);
    return {~irq_on, ~under, ~over, 1'b0, iso0, iso1, ~hot, 1'b1};
  endfunction
  task automatic rd_status;
    u_host.rd(BASE + wsm_pkg::OFS_STATUS, d);
  endtask
  task automatic wr(input logic [9:0] ofs, input logic [7:0] v, input logic dma);
    u_host.wr(BASE + ofs, v, dma);
  endtask
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_reset;
    check({buzzer, data_oe, wd_reset, wd_reset_n}, 4'h1, "idle after reset");
  endtask
  task automatic t_status;
    logic [4:0] prev, cur;
    logic       ev;
    logic [15:0] want_irq;
    for (int i = 0; i < 32; i++) begin
      prev = {iso0, iso1, over, under, hot};
      cur = i[4:0];
      irq_sel = i[1] ? 4'hF : (i[4] ? 4'hD : 4'h5);
      {iso0, iso1, over, under, hot} = cur;
      temp_adc = 8'(i * 37);
      ev = (prev[4:3] != cur[4:3]) || (|(cur[2:0] & ~prev[2:0]));
      u_host.edges(6);
      rd_status;
      check(d, status_want(ev), "status after change");
      want_irq = ev ? ((16'h0001 << irq_sel) & IRQ_LINES) : 16'h0000;
      check(irq_oe, want_irq, "irq line");
      check(irq_out, want_irq, "irq level");
      u_host.edges(120);
      rd_status;
      check(d, status_want(1'b0), "status settled");
      u_host.rd(BASE + wsm_pkg::OFS_ISO, d);
      check(d, {6'h00, iso1, iso0}, "isolated inputs");
      u_host.rd(BASE + wsm_pkg::OFS_TEMP, d);
      check(d, temp_adc, "temperature");
    end
  endtask
  task automatic t_fan;
    fan_run = 1'b0;
    u_host.edges(245);
    rd_status;
    check({d[wsm_pkg::ST_FANOK], d[wsm_pkg::ST_IRQ]}, 2'b10, "fan failed");
    fan_run = 1'b1;
    u_host.edges(130);
    rd_status;
    check(d, status_want(1'b0), "fan good again");
  endtask
  task automatic t_buzzer;
    wr(wsm_pkg::OFS_CTRL, 8'hB2, 1'b0);
    wr(wsm_pkg::OFS_BUZ_ON, 8'h00, 1'b0);
    check(buzzer, 1'b1, "buzzer on");
    wr(wsm_pkg::OFS_BUZOFF, 8'hFF, 1'b0);
    check(buzzer, 1'b0, "buzzer off");
    wr(wsm_pkg::OFS_BUZ_ON, 8'h00, 1'b1);
    u_host.wr(BASE ^ 10'h100 + wsm_pkg::OFS_BUZ_ON, 8'h00, 1'b0);
    check(buzzer, 1'b0, "foreign cycles ignored");
    wr(wsm_pkg::OFS_CTRL, 8'hB0, 1'b0);
    wr(wsm_pkg::OFS_BUZ_ON, 8'h00, 1'b0);
    check(buzzer, 1'b0, "mode 0 silent");
    wr(wsm_pkg::OFS_CTRL, 8'hB2, 1'b0);
    rd_status;
    rd_status;
    check(buzzer, 1'b1, "mode 1 releases latch");
    wr(wsm_pkg::OFS_CTRL, 8'hC0, 1'b0);
    wr(wsm_pkg::OFS_STATUS, 8'h00, 1'b0);
    check(buzzer, 1'b1, "ignored writes");
    wr(wsm_pkg::OFS_BUZOFF, 8'h00, 1'b0);
    check(buzzer, 1'b0, "buzzer off again");
    base_sel = 10'h000;
    u_host.edges(4);
    u_host.wr(wsm_pkg::OFS_BUZ_ON, 8'h00, 1'b0);
    check(buzzer, 1'b1, "moved base decoded");
    u_host.wr(BASE + wsm_pkg::OFS_BUZOFF, 8'h00, 1'b0);
    check(buzzer, 1'b1, "old base ignored");
    u_host.wr(wsm_pkg::OFS_BUZOFF, 8'h00, 1'b0);
    check(buzzer, 1'b0, "moved base off");
    base_sel = BASE;
    u_host.edges(4);
    ce = 1'b0;
    wr(wsm_pkg::OFS_BUZ_ON, 8'h00, 1'b0);
    check(buzzer, 1'b0, "write ignored while frozen");
    ce = 1'b1;
    u_host.edges(4);
    check(buzzer, 1'b0, "no stale write after freeze");
  endtask
  task automatic t_watchdog;
    int n;
    wr(wsm_pkg::OFS_CTRL, 8'h34, 1'b0);
    wr(wsm_pkg::OFS_CTRL, 8'h74, 1'b0);
    u_host.load(BASE + wsm_pkg::OFS_CNT0, 16'h0002);
    u_host.load(BASE + wsm_pkg::OFS_CNT1, 16'h0003);
    u_host.rd(BASE + wsm_pkg::OFS_CNT1, d);
    check(d, 8'h03, "count readback");
    n = 0;
    do begin
      rd_status;
      n++;
    end while (d[wsm_pkg::ST_REMIND] !== 1'b0 && n < 150);
    check({d[wsm_pkg::ST_REMIND], d[wsm_pkg::ST_IRQ], wd_reset}, 3'b000, "reminder");
    // One first-counter period is two ticks of about 112 cycles
    n = 0;
    while (wd_reset !== 1'b1 && n < 600) begin
      u_host.edges(1);
      n++;
    end
    check(n > 100 && n < 400, 1'b1, "timeout spacing");
    check(wd_reset_n, 1'b0, "reset pair");
    n = 0;
    while (wd_reset === 1'b1 && n < 300) begin
      u_host.edges(1);
      n++;
    end
    check(n >= 50 && n < 300, 1'b1, "reset hold");
  endtask
  initial begin
    {iso0, iso1, over, under, hot} = 5'h00;
    fan_run = 1'b1;
    irq_sel = 4'h5;
    ce = 1'b1;
    base_sel = BASE;
    temp_adc = 8'h00;
    errors = 0;
    tests_run = 0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    u_host.edges(30);
    t_reset;
    t_status;
    t_fan;
    t_buzzer;
    t_watchdog;
    results;
  end
endmodule
bind wsm_top wsm_top_checker #(.RST_HOLD_CYC(RST_HOLD_CYC)) u_wsm_top_checker (
  .clk(clk), .rst(rst), .aen(aen), .ior_n(ior_n), .iow_n(iow_n), .data_oe(data_oe),
  .irq_out(irq_out), .irq_oe(irq_oe), .wd_reset(wd_reset), .wd_reset_n(wd_reset_n),
  .buzzer(buzzer));
